//--- rtl/dta_top.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dta_top #(
   parameter int unsigned ADDR_W  = 18,
   parameter int unsigned SMP_W   = 14,
   parameter int unsigned TS_W    = 64,
   parameter int unsigned PRE_MAX = 8176
) (
   input  wire logic               core_clk,
   input  wire logic               reset_n,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               trigger_in,
   input  wire logic [SMP_W-1:0]   sample_in,
   output logic                    fast_valid,
   output logic [SMP_W-1:0]        fast_data,
   output logic                    segment_start,
   output logic [TS_W-1:0]         segment_first_index,
   output logic                    slow_valid,
   output logic [SMP_W-1:0]        slow_data,
   output logic                    trig_stamp_valid,
   output logic [TS_W-1:0]         trig_stamp,
   output logic                    first_slow_stamp_valid,
   output logic [TS_W-1:0]         first_slow_stamp,
   output logic                    acq_busy
);
   import dta_pkg::*;

   initial
   begin
      if (ADDR_W < 18) $error("address width too small for register map");
      if (SMP_W < 1 || SMP_W > 32) $error("sample width out of range");
      if (TS_W < 33) $error("stamp width too small");
   end

   // ----------------------------------------
   // registers and state
   // ----------------------------------------
   logic [31:0]       mode_reg;
   logic [31:0]       total_reg;
   logic [31:0]       seg_size_reg;
   logic [31:0]       loops_reg;
   logic [31:0]       post_reg;
   logic [31:0]       divider_reg;
   logic [31:0]       stamp_reg;
   logic [31:0]       segs_done_reg;
   logic [31:0]       samples_done_reg;
   logic [31:0]       post_cnt_reg;
   logic [31:0]       pre_fill_reg;
   logic              cfg_err_reg;
   logic              pre_err_reg;
   dta_state_t        state_reg;
   dta_state_t        state_next;
   logic              aw_have_reg;
   logic              w_have_reg;
   logic [15:0]       aw_idx_reg;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic              wr_do;
   logic [31:0]       wr_val;
   logic              wr_hit;
   logic              wr_bad;
   logic              start_req;
   logic              stop_req;
   logic [31:0]       pre_len;
   logic              mode_ok;
   logic              start_ok;
   logic              running;
   logic              trig_take;
   logic              seg_last;
   logic              seg_finish;
   logic              slow_tick;
   logic [TS_W-1:0]   ts_count;
   logic [32:0]       samples_after;

   // ----------------------------------------
   // derived configuration
   // ----------------------------------------
   assign pre_len  = seg_size_reg - post_reg;
   assign mode_ok  = (mode_reg == MODE_MEMORY_DUAL) || (mode_reg == MODE_STREAMING_DUAL);
   assign start_ok = start_req && mode_ok && (post_reg != 32'h0000_0000)
                     && (post_reg <= seg_size_reg) && (pre_len <= PRE_MAX)
                     && (state_reg == ST_IDLE || state_reg == ST_DONE);
   assign running  = (state_reg == ST_ARMED) || (state_reg == ST_POST);
   assign trig_take = (state_reg == ST_ARMED) && trigger_in && !stop_req
                      && (pre_fill_reg >= pre_len);
   assign seg_last  = (state_reg == ST_POST) && (post_cnt_reg == post_reg - 1'b1);
   assign samples_after = {1'b0, samples_done_reg} + {1'b0, seg_size_reg};

   always_comb
   begin
      seg_finish = 1'b0;
      if (mode_reg == MODE_STREAMING_DUAL)
      begin
         seg_finish = (loops_reg != 32'h0000_0000)
                      && (segs_done_reg + 1'b1 == loops_reg);
      end
      else
      begin
         seg_finish = samples_after >= {1'b0, total_reg};
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
   assign wr_do         = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         aw_have_reg <= 1'b0;
         aw_idx_reg  <= 16'h0000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_reg <= 1'b1;
         aw_idx_reg  <= s_axi_awaddr[17:2];
      end
      else if (wr_do)
      begin
         aw_have_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_do)
      begin
         w_have_reg <= 1'b0;
      end
   end

   always_comb
   begin
      wr_hit = 1'b1;
      wr_val = dta_merge(32'h0000_0000, w_data_reg, w_strb_reg);
      unique case (aw_idx_reg)
         IDX_MODE:     wr_val = dta_merge(mode_reg, w_data_reg, w_strb_reg);
         IDX_TOTAL:    wr_val = dta_merge(total_reg, w_data_reg, w_strb_reg);
         IDX_SEG_SIZE: wr_val = dta_merge(seg_size_reg, w_data_reg, w_strb_reg);
         IDX_LOOPS:    wr_val = dta_merge(loops_reg, w_data_reg, w_strb_reg);
         IDX_POST:     wr_val = dta_merge(post_reg, w_data_reg, w_strb_reg);
         IDX_DIVIDER:  wr_val = dta_merge(divider_reg, w_data_reg, w_strb_reg);
         IDX_STAMP:    wr_val = dta_merge(stamp_reg, w_data_reg, w_strb_reg);
         IDX_CTRL:     wr_hit = 1'b1;
         default:      wr_hit = 1'b0;
      endcase
      wr_bad = !wr_hit || ((aw_idx_reg == IDX_DIVIDER)
               && ((wr_val < DIV_MIN) || (wr_val > DIV_MAX)
               || ((wr_val & DIV_STEP_MASK) != 32'h0000_0000)));
   end

   assign start_req = wr_do && (aw_idx_reg == IDX_CTRL) && w_strb_reg[0]
                      && w_data_reg[CTRL_START_BIT];
   assign stop_req  = wr_do && (aw_idx_reg == IDX_CTRL) && w_strb_reg[0]
                      && w_data_reg[CTRL_STOP_BIT];

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         mode_reg     <= RST_MODE;
         total_reg    <= RST_TOTAL;
         seg_size_reg <= RST_SEG_SIZE;
         loops_reg    <= RST_LOOPS;
         post_reg     <= RST_POST;
         divider_reg  <= RST_DIVIDER;
         stamp_reg    <= RST_STAMP;
      end
      else if (wr_do && !wr_bad)
      begin
         unique case (aw_idx_reg)
            IDX_MODE:     mode_reg     <= wr_val;
            IDX_TOTAL:    total_reg    <= wr_val;
            IDX_SEG_SIZE: seg_size_reg <= wr_val;
            IDX_LOOPS:    loops_reg    <= wr_val;
            IDX_POST:     post_reg     <= wr_val;
            IDX_DIVIDER:  divider_reg  <= wr_val;
            IDX_STAMP:    stamp_reg    <= wr_val;
            default:      mode_reg     <= mode_reg;
         endcase
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr[17:2])
            IDX_MODE:      s_axi_rdata <= mode_reg;
            IDX_TOTAL:     s_axi_rdata <= total_reg;
            IDX_SEG_SIZE:  s_axi_rdata <= seg_size_reg;
            IDX_LOOPS:     s_axi_rdata <= loops_reg;
            IDX_POST:      s_axi_rdata <= post_reg;
            IDX_DIVIDER:   s_axi_rdata <= divider_reg;
            IDX_STAMP:     s_axi_rdata <= stamp_reg;
            IDX_CTRL:      s_axi_rdata <= 32'h0000_0000;
            IDX_SEGS_DONE: s_axi_rdata <= segs_done_reg;
            IDX_STATUS:
            begin
               s_axi_rdata                 <= 32'h0000_0000;
               s_axi_rdata[ST_RUN_BIT]     <= running;
               s_axi_rdata[ST_POST_BIT]    <= state_reg == ST_POST;
               s_axi_rdata[ST_DONE_BIT]    <= state_reg == ST_DONE;
               s_axi_rdata[ST_CFG_ERR_BIT] <= cfg_err_reg;
               s_axi_rdata[ST_PRE_ERR_BIT] <= pre_err_reg;
            end
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // acquisition sequencer
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE, ST_DONE:
         begin
            if (start_ok)
            begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED:
         begin
            if (stop_req)
            begin
               state_next = ST_DONE;
            end
            else if (trig_take)
            begin
               state_next = ST_POST;
            end
         end
         ST_POST:
         begin
            if (stop_req)
            begin
               state_next = ST_DONE;
            end
            else if (seg_last)
            begin
               state_next = seg_finish ? ST_DONE : ST_ARMED;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || start_ok)
      begin
         pre_fill_reg <= 32'h0000_0000;
      end
      else if (state_reg != ST_ARMED)
      begin
         pre_fill_reg <= 32'h0000_0000;
      end
      else if (pre_fill_reg < pre_len)
      begin
         pre_fill_reg <= pre_fill_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || trig_take)
      begin
         post_cnt_reg <= 32'h0000_0000;
      end
      else if (state_reg == ST_POST)
      begin
         post_cnt_reg <= post_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || start_ok)
      begin
         segs_done_reg    <= 32'h0000_0000;
         samples_done_reg <= 32'h0000_0000;
      end
      else if (seg_last && !stop_req)
      begin
         segs_done_reg    <= segs_done_reg + 1'b1;
         samples_done_reg <= samples_after[31:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         cfg_err_reg <= 1'b0;
         pre_err_reg <= 1'b0;
      end
      else if (start_req)
      begin
         cfg_err_reg <= !start_ok;
         pre_err_reg <= (post_reg <= seg_size_reg) && (pre_len > PRE_MAX);
      end
   end

   // ----------------------------------------
   // sample outputs
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         fast_valid          <= 1'b0;
         fast_data           <= '0;
         slow_valid          <= 1'b0;
         slow_data           <= '0;
         segment_start       <= 1'b0;
         segment_first_index <= '0;
      end
      else
      begin
         fast_valid    <= state_reg == ST_POST;
         fast_data     <= sample_in;
         slow_valid    <= slow_tick;
         segment_start <= trig_take;
         if (slow_tick)
         begin
            slow_data <= sample_in;
         end
         if (trig_take)
         begin
            segment_first_index <= ts_count - TS_W'(pre_len);
         end
      end
   end

   assign acq_busy = running;

   // ----------------------------------------
   // divider and stamp units
   // ----------------------------------------
   dta_slow_div #(.DIV_W(19)) u_slow_div (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clear    (start_ok),
      .run      (running),
      .divider  (divider_reg[18:0]),
      .tick     (slow_tick)
   );

   dta_stamp #(.TS_W(TS_W)) u_stamp (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .clear      (start_ok),
      .run        (running),
      .setup      (stamp_reg),
      .trig_in    (trig_take),
      .slow_in    (slow_tick),
      .count      (ts_count),
      .trig_valid (trig_stamp_valid),
      .trig_value (trig_stamp),
      .slow_valid (first_slow_stamp_valid),
      .slow_value (first_slow_stamp)
   );
endmodule : dta_top

//--- rtl/dta_pkg.sv
package dta_pkg;
   // ----------------------------------------
   // clock and register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam logic [15:0] IDX_MODE      = 16'd9500;
   localparam logic [15:0] IDX_CTRL      = 16'd9600;
   localparam logic [15:0] IDX_STATUS    = 16'd9601;
   localparam logic [15:0] IDX_SEGS_DONE = 16'd9602;
   localparam logic [15:0] IDX_TOTAL     = 16'd10000;
   localparam logic [15:0] IDX_SEG_SIZE  = 16'd10010;
   localparam logic [15:0] IDX_LOOPS     = 16'd10020;
   localparam logic [15:0] IDX_POST      = 16'd10030;
   localparam logic [15:0] IDX_DIVIDER   = 16'd10040;
   localparam logic [15:0] IDX_STAMP     = 16'd47000;
   // ----------------------------------------
   // field layouts and encodings
   // ----------------------------------------
   localparam logic [31:0] MODE_STREAMING_DUAL = 32'h0000_0080;
   localparam logic [31:0] MODE_MEMORY_DUAL    = 32'h0000_0800;
   localparam logic [31:0] STAMP_FEATURE_MASK  = 32'h000f_0000;
   localparam logic [31:0] STAMP_FIRST_SLOW    = 32'h0001_0000;
   localparam logic [31:0] STAMP_FEATURE_OFF   = 32'h0000_0000;
   localparam logic [31:0] STAMP_MODE_MASK     = 32'h0000_ffff;
   localparam int unsigned CTRL_START_BIT      = 0;
   localparam int unsigned CTRL_STOP_BIT       = 1;
   localparam int unsigned ST_RUN_BIT          = 0;
   localparam int unsigned ST_POST_BIT         = 1;
   localparam int unsigned ST_DONE_BIT         = 2;
   localparam int unsigned ST_CFG_ERR_BIT      = 3;
   localparam int unsigned ST_PRE_ERR_BIT      = 4;
   localparam logic [31:0] DIV_MIN             = 32'd8;
   localparam logic [31:0] DIV_MAX             = 32'd524280;
   localparam logic [31:0] DIV_STEP_MASK       = 32'h0000_0007;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [31:0] RST_MODE     = 32'h0000_0000;
   localparam logic [31:0] RST_TOTAL    = 32'h0000_0000;
   localparam logic [31:0] RST_SEG_SIZE = 32'h0000_0000;
   localparam logic [31:0] RST_LOOPS    = 32'h0000_0000;
   localparam logic [31:0] RST_POST     = 32'h0000_0000;
   localparam logic [31:0] RST_DIVIDER  = 32'h0000_0008;
   localparam logic [31:0] RST_STAMP    = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_POST, ST_DONE} dta_state_t;

   function automatic logic [31:0] dta_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : dta_merge
endpackage : dta_pkg

//--- rtl/dta_slow_div.sv
`timescale 1ns/10ps
module dta_slow_div #(
   parameter int unsigned DIV_W = 19
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divider,
   output logic                  tick
);
   import dta_pkg::*;

   initial
   begin
      if (DIV_W < 19) $error("divider width too small");
   end

   logic [DIV_W-1:0] cnt_reg;

   // ----------------------------------------
   // divided enable, sampling clock untouched
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || clear)
      begin
         cnt_reg <= '0;
      end
      else if (run)
      begin
         if (cnt_reg >= divider - 1'b1)
         begin
            cnt_reg <= '0;
         end
         else
         begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   assign tick = run && !clear && (cnt_reg >= divider - 1'b1);
endmodule : dta_slow_div

//--- rtl/dta_stamp.sv
`timescale 1ns/10ps
module dta_stamp #(
   parameter int unsigned TS_W = 64
) (
   input  wire logic            core_clk,
   input  wire logic            reset_n,
   input  wire logic            clear,
   input  wire logic            run,
   input  wire logic [31:0]     setup,
   input  wire logic            trig_in,
   input  wire logic            slow_in,
   output logic [TS_W-1:0]      count,
   output logic                 trig_valid,
   output logic [TS_W-1:0]      trig_value,
   output logic                 slow_valid,
   output logic [TS_W-1:0]      slow_value
);
   import dta_pkg::*;

   initial
   begin
      if (TS_W < 32) $error("stamp width too small");
   end

   logic active;
   logic first_pend_reg;

   assign active = (setup & STAMP_MODE_MASK) != 32'h0000_0000;

   // ----------------------------------------
   // counter on fast timebase
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || clear)
      begin
         count <= '0;
      end
      else if (run)
      begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         trig_valid <= 1'b0;
         trig_value <= '0;
      end
      else
      begin
         trig_valid <= active && trig_in;
         if (trig_in)
         begin
            trig_value <= count;
         end
      end
   end

   // ----------------------------------------
   // optional stamp of first slow sample
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         first_pend_reg <= 1'b0;
         slow_valid     <= 1'b0;
         slow_value     <= '0;
      end
      else if (clear)
      begin
         first_pend_reg <= (setup & STAMP_FIRST_SLOW) != STAMP_FEATURE_OFF;
         slow_valid     <= 1'b0;
      end
      else
      begin
         slow_valid <= first_pend_reg && slow_in && active;
         if (first_pend_reg && slow_in)
         begin
            first_pend_reg <= 1'b0;
            slow_value     <= count;
         end
      end
   end
endmodule : dta_stamp

//--- testbench/dta_chk.sv
`timescale 1ns/10ps
module dta_chk (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        segment_start,
   input wire logic        fast_valid,
   input wire logic        slow_valid,
   input wire logic        trig_stamp_valid,
   input wire logic        first_slow_stamp_valid,
   input wire logic        acq_busy
);
   // ----------------------------------------
   // port checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_post_run; ##[0:2] fast_valid; endsequence
   sequence s_gap; !slow_valid [*7]; endsequence
   property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   property p_ar; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_rd; s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata); endproperty
   property p_seg; trig_stamp_valid |-> segment_start; endproperty
   property p_fast; segment_start |-> s_post_run; endproperty
   property p_busy; segment_start |-> acq_busy; endproperty
   property p_slow; slow_valid |=> s_gap; endproperty
   property p_first; first_slow_stamp_valid |-> slow_valid; endproperty
   a_b: assert property (p_b) else $error("bvalid dropped");
   a_r: assert property (p_r) else $error("rvalid dropped");
   a_ar: assert property (p_ar) else $error("no read answer");
   a_rd: assert property (p_rd) else $error("rdata moved");
   a_seg: assert property (p_seg) else $error("stamp off trigger");
   a_fast: assert property (p_fast) else $error("no fast data");
   a_busy: assert property (p_busy) else $error("segment while idle");
   a_slow: assert property (p_slow) else $error("slow ticks too close");
   a_first: assert property (p_first) else $error("first stamp off tick");
endmodule : dta_chk
bind dta_top dta_chk u_chk (.*);

//--- testbench/dta_top_tb.sv
`timescale 1ns/10ps
module dta_top_tb;
   import dta_pkg::*;
   logic        core_clk = 0, reset_n = 0, trigger_in = 0, s_axi_awvalid = 0;
   logic        s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [13:0] sample_in = 0, ps = 0, fast_data, slow_data;
   logic [63:0] segment_first_index, trig_stamp, first_slow_stamp;
   logic        fast_valid, segment_start, slow_valid, trig_stamp_valid;
   logic        first_slow_stamp_valid, acq_busy;
   int          error_cnt = 0, checks_done = 0, segs, fsts, nfast, gap, pv, pre, div;
   int          tsm = 0, fexp = 1;
   dta_top uut (.*);
   // ----------------------------------------
   // clock, stimulus, monitor, tasks
   // ----------------------------------------
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      trigger_in <= $urandom;
      sample_in <= $urandom;
      nfast += fast_valid;
      fsts += first_slow_stamp_valid;
      gap++;
      if (fast_valid === 1) chk("fast_data", ps, fast_data);
      if (first_slow_stamp_valid === 1)
         chk("first_slow_stamp", div - 1, first_slow_stamp);
      if (segment_start === 1)
      begin
         segs++;
         chk("trig_stamp_valid", 1, trig_stamp_valid);
         chk("trig_stamp", tsm - 1, trig_stamp);
         chk("first_index", trig_stamp - pre, segment_first_index);
      end
      if (slow_valid === 1)
      begin
         chk("slow_data", ps, slow_data);
         if (pv) chk("slow_gap", div, gap);
         gap = 0;
         pv = 1;
      end
      tsm = (acq_busy === 1) ? tsm + 1 : 0;
      ps = sample_in;
   end
   task chk(string n, logic [63:0] e, logic [63:0] g);
      checks_done++;
      if (e !== g)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(logic [15:0] i, logic [31:0] d, logic [1:0] e);
      @(posedge core_clk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      while (s_axi_bvalid !== 1);
      s_axi_bready <= 0;
      chk("bresp", e, s_axi_bresp);
   endtask : wr
   task rd(logic [15:0] i, logic [31:0] d, logic [1:0] e);
      @(posedge core_clk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      while (s_axi_rvalid !== 1);
      s_axi_rready <= 0;
      chk("rdata", d, s_axi_rdata);
      chk("rresp", e, s_axi_rresp);
   endtask : rd
   task run(logic [31:0] m, sg, po, tot, lp, int n);
      pre = sg - po;
      wr(IDX_MODE, m, RESP_OKAY);
      wr(IDX_SEG_SIZE, sg, RESP_OKAY);
      wr(IDX_POST, po, RESP_OKAY);
      wr(IDX_TOTAL, tot, RESP_OKAY);
      wr(IDX_LOOPS, lp, RESP_OKAY);
      segs = 0;
      fsts = 0;
      nfast = 0;
      wr(IDX_CTRL, 32'h1, RESP_OKAY);
      pv = 0;
      if (n == 0)
      begin
         repeat (400) @(posedge core_clk);
         chk("busy", 1, acq_busy);
         wr(IDX_CTRL, 32'h2, RESP_OKAY);
      end
      for (int k = 0; k < 9000 && acq_busy !== 0; k++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
      chk("busy_end", 0, acq_busy);
      chk("first_slow", fexp, fsts);
      if (n > 0) chk("segments", n, segs);
      if (n > 0) chk("fast_samples", n * po, nfast);
   endtask : run
   task summarize;
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   initial
   begin
      #300000;
      error_cnt++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'h670e));
      repeat (12) @(posedge core_clk);
      reset_n <= 1;
      rd(IDX_DIVIDER, RST_DIVIDER, RESP_OKAY);
      rd(IDX_STAMP, RST_STAMP, RESP_OKAY);
      rd(16'd1234, 32'h0, RESP_SLVERR);
      wr(IDX_DIVIDER, 32'd12, RESP_SLVERR);
      wr(IDX_DIVIDER, 32'd524288, RESP_SLVERR);
      wr(IDX_DIVIDER, DIV_MAX, RESP_OKAY);
      rd(IDX_DIVIDER, DIV_MAX, RESP_OKAY);
      div = 8 * (1 + $urandom % 4);
      wr(IDX_DIVIDER, div, RESP_OKAY);
      wr(IDX_STAMP, STAMP_FIRST_SLOW | 32'h1, RESP_OKAY);
      rd(IDX_STAMP, STAMP_FIRST_SLOW | 32'h1, RESP_OKAY);
      run(MODE_MEMORY_DUAL, 16, 8, 48, 0, 3);
      rd(IDX_SEGS_DONE, 32'd3, RESP_OKAY);
      run(MODE_STREAMING_DUAL, 12, 4, 0, 3, 3);
      wr(IDX_STAMP, 32'h1, RESP_OKAY);
      fexp = 0;
      run(MODE_STREAMING_DUAL, 12, 4, 0, 0, 0);
      wr(IDX_SEG_SIZE, 32'd8200, RESP_OKAY);
      wr(IDX_CTRL, 32'h1, RESP_OKAY);
      rd(IDX_STATUS, (1 << ST_DONE_BIT) | (1 << ST_CFG_ERR_BIT) | (1 << ST_PRE_ERR_BIT),
         RESP_OKAY);
      chk("busy_refused", 0, acq_busy);
      summarize();
   end
endmodule : dta_top_tb
